// File: common/crxb_pkg.sv
// Package of constants, types and register map for the CAN receive buffer registers.
package crxb_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [11:0] ADDR_CON0 = 12'h000;
	localparam logic [11:0] ADDR_CON1 = 12'h004;
	localparam logic [11:0] ADDR_OVFL = 12'h008;
	localparam logic [11:0] ADDR_BUF0 = 12'h040;
	localparam logic [11:0] ADDR_BUF1 = 12'h080;
	localparam logic [11:0] BUF_SPAN = 12'h040;
	localparam logic [5:0] OFS_SIDH = 6'h00;
	localparam logic [5:0] OFS_SIDL = 6'h04;
	localparam logic [5:0] OFS_EIDH = 6'h08;
	localparam logic [5:0] OFS_EIDL = 6'h0C;
	localparam logic [5:0] OFS_DLC = 6'h10;
	localparam logic [5:0] OFS_DATA = 6'h20;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_FULL = 7;
	localparam int BIT_MODE_HI = 6;
	localparam int BIT_MODE_LO = 5;
	localparam int BIT_RTR_STAT = 3;
	localparam int BIT_DBEN = 2;
	localparam int BIT_JUMP_TABLE_OFFSET_BIT = 1;
	localparam int BIT_OVFL0 = 7;
	localparam int BIT_OVFL1 = 6;
	localparam int BIT_DLC_RTR = 6;
	localparam int BIT_SIDL_SRR = 4;
	localparam int BIT_SIDL_EXT = 3;

	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] MODE_ALL_ERR = 2'b11;
	localparam logic [1:0] MODE_EXT = 2'b10;
	localparam logic [1:0] MODE_STD = 2'b01;
	localparam logic [1:0] MODE_VALID = 2'b00;
	localparam logic [2:0] HIT_LAST = 3'b101;
	localparam int NUM_DATA = 8;

	typedef enum logic {CRXB_IDLE, CRXB_COMMIT} crxb_state_e;

	// One message as delivered by the receive path and filters.
	typedef struct packed {
		logic [28:0] ident;
		logic ext;
		logic rtr;
		logic [3:0] dlc;
		logic [63:0] data;
		logic valid_frame;
		logic [2:0] filter_hit;
	} crxb_msg_s;

	// Stored header of one buffer; the data bytes are held apart.
	typedef struct packed {
		logic [28:0] ident;
		logic ext;
		logic rtr;
		logic [3:0] dlc;
		logic [2:0] hit;
	} crxb_hdr_s;

endpackage

// File: design/crxb_top.sv
// CAN receive buffer pair with APB register access and double-buffer rollover.
//
// Notes on behaviour
// - Hardware sets a buffer's full flag once a message is stored there.
// - Mode 11 all incl. errors, 10 valid extended, 01 valid standard, 00 valid.
// - With double buffering on, a message meeting full buffer 0 goes to buffer 1.
// - Buffer 0 control bit 1 is a read-only copy of double-buffer enable.
// - Jump offset bit 1 gives offsets 6/7, bit 0 gives offsets 1/0.
// - Buffer 0 filter-hit bit records filter 1 or filter 0.
// - Buffer 1 filter-hit field reports filters 0 to 5; 110 and 111 reserved.
// - Buffer 1 reports filter 0 or 1 only after rollover with enable set.
// - Full flag and mode are held separately per buffer.
// - Control bit 3 is read-only remote-request status of the stored message.
// - Identifier high byte holds SID 10:3 or EID 28:21.
// - Identifier low bits 7:5 hold SID 2:0 or EID 20:18.
// - Substitute bit reads 0 for extended, remote status for standard frames.
// - Identifier low bit 3 marks an extended frame.
// - EID 17:16 in low byte bits 1:0; EID 15:0 in two extended bytes.
// - Length code 0 to 8 valid; 9 to 15 invalid but stored as received.
// - Length register bit 6 holds the frame's remote request bit.
// - Length register bits 5:4 read as zero.
// - Each buffer has eight data byte registers in received order.
// - Overflow flag set when a message meets a full buffer; software clears it.
`timescale 1ns/1ns
`default_nettype none

module crxb_top (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic msg_valid,
	input wire crxb_pkg::crxb_msg_s msg_in,
	output logic msg_ack,
	output logic msg_dropped
);
	import crxb_pkg::*;

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta_r;
	logic rst_sync_r;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end
	wire logic rst_n = rst_sync_r;

	// ****************************************
	// Storage
	// ****************************************
	logic [1:0] full_r;
	logic [1:0] mode_r [2];
	logic [1:0] ovfl_r;
	logic dben_r;
	crxb_hdr_s hdr_r [2];
	logic [7:0] data_r [2][NUM_DATA];
	crxb_state_e state_r;
	logic dest_r;
	logic [1:0] set_full;

	// Mode acceptance for one buffer.
	function automatic logic mode_accepts(input logic [1:0] mode, input crxb_msg_s m);
		logic ok;
		ok = 1'b0;
		case (mode)
			MODE_ALL_ERR: ok = 1'b1;
			MODE_EXT: ok = m.valid_frame && m.ext;
			MODE_STD: ok = m.valid_frame && !m.ext;
			default: ok = m.valid_frame;
		endcase
		return ok;
	endfunction

	// ****************************************
	// APB decode
	// ****************************************
	wire logic acc = psel && penable;
	wire logic wr = acc && pwrite && pstrb[0];
	wire logic hit_c0 = (paddr == ADDR_CON0);
	wire logic hit_c1 = (paddr == ADDR_CON1);
	wire logic hit_ov = (paddr == ADDR_OVFL);
	// Clear requests take effect only on the access edge.
	wire logic clr0 = wr && hit_c0 && !pwdata[BIT_FULL];
	wire logic clr1 = wr && hit_c1 && !pwdata[BIT_FULL];

	// ****************************************
	// Receive path
	// ****************************************
	// Filter 0/1 messages route to buffer 0 first, then roll into buffer 1 when double buffering is on; filters 2 to 5 go to buffer 1.
	logic take0;
	logic take1;
	logic roll;
	always_comb begin
		take0 = 1'b0;
		take1 = 1'b0;
		roll = 1'b0;
		if (msg_valid && state_r == CRXB_IDLE) begin
			if (msg_in.filter_hit <= 3'd1) begin
				if (mode_accepts(mode_r[0], msg_in)) begin
					if (!full_r[0]) begin
						take0 = 1'b1;
					end else if (dben_r && !full_r[1] && mode_accepts(mode_r[1], msg_in)) begin
						take1 = 1'b1;
						roll = 1'b1;
					end
				end
			end else if (msg_in.filter_hit <= HIT_LAST) begin
				take1 = !full_r[1] && mode_accepts(mode_r[1], msg_in);
			end
		end
	end

	// A message meeting a full destination is an overflow of that buffer.
	wire logic want0 = msg_valid && state_r == CRXB_IDLE && msg_in.filter_hit <= 3'd1 &&
		mode_accepts(mode_r[0], msg_in);
	wire logic want1 = msg_valid && state_r == CRXB_IDLE && ((want0 && dben_r && full_r[0]) ||
		(msg_in.filter_hit > 3'd1 && msg_in.filter_hit <= HIT_LAST && mode_accepts(mode_r[1], msg_in)));
	wire logic ov0 = want0 && full_r[0] && !dben_r;
	wire logic ov1 = want1 && full_r[1];

	// Contents are stored first; the full flag rises one edge later.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= CRXB_IDLE;
			dest_r <= 1'b0;
		end else begin
			case (state_r)
				CRXB_IDLE: begin
					if (take0 || take1) begin
						state_r <= CRXB_COMMIT;
						dest_r <= take1;
					end
				end
				default: state_r <= CRXB_IDLE;
			endcase
		end
	end
	assign set_full[0] = (state_r == CRXB_COMMIT) && !dest_r;
	assign set_full[1] = (state_r == CRXB_COMMIT) && dest_r;

	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_buf
			wire logic take_b = (b == 0) ? take0 : take1;
			always_ff @(posedge core_clk) begin
				if (take_b) begin
					hdr_r[b].ident <= msg_in.ident;
					hdr_r[b].ext <= msg_in.ext;
					hdr_r[b].rtr <= msg_in.rtr;
					hdr_r[b].dlc <= msg_in.dlc;
					hdr_r[b].hit <= (b == 0) ? {2'b00, msg_in.filter_hit[0]} : msg_in.filter_hit;
					for (int i = 0; i < NUM_DATA; i++) begin
						data_r[b][i] <= msg_in.data[i*8 +: 8];
					end
				end
			end
			// Set wins over a clear arriving in the same cycle.
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					full_r[b] <= 1'b0;
				end else if (set_full[b]) begin
					full_r[b] <= 1'b1;
				end else if ((b == 0) ? clr0 : clr1) begin
					full_r[b] <= 1'b0;
				end
			end
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					mode_r[b] <= CTRL_RESET[1:0];
				end else if (wr && ((b == 0) ? hit_c0 : hit_c1)) begin
					mode_r[b] <= pwdata[BIT_MODE_HI:BIT_MODE_LO];
				end
			end
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					ovfl_r[b] <= 1'b0;
				end else if ((b == 0) ? ov0 : ov1) begin
					ovfl_r[b] <= 1'b1;
				end else if (wr && hit_ov && !pwdata[(b == 0) ? BIT_OVFL0 : BIT_OVFL1]) begin
					ovfl_r[b] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dben_r <= CTRL_RESET[BIT_DBEN];
		end else if (wr && hit_c0) begin
			dben_r <= pwdata[BIT_DBEN];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			msg_ack <= 1'b0;
			msg_dropped <= 1'b0;
		end else begin
			msg_ack <= take0 || take1;
			msg_dropped <= msg_valid && state_r == CRXB_IDLE && !take0 && !take1;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	function automatic logic [7:0] buf_byte(input logic [5:0] ofs, input crxb_hdr_s h,
		input logic [7:0] d [NUM_DATA]);
		logic [7:0] v;
		v = 8'h00;
		if (ofs == OFS_SIDH) begin
			v = h.ext ? h.ident[28:21] : h.ident[10:3];
		end else if (ofs == OFS_SIDL) begin
			v[7:5] = h.ext ? h.ident[20:18] : h.ident[2:0];
			v[BIT_SIDL_SRR] = h.ext ? 1'b0 : h.rtr;
			v[BIT_SIDL_EXT] = h.ext;
			v[1:0] = h.ext ? h.ident[17:16] : 2'b00;
		end else if (ofs == OFS_EIDH) begin
			v = h.ext ? h.ident[15:8] : 8'h00;
		end else if (ofs == OFS_EIDL) begin
			v = h.ext ? h.ident[7:0] : 8'h00;
		end else if (ofs == OFS_DLC) begin
			v = {1'b0, h.rtr, 2'b00, h.dlc};
		end else if (ofs >= OFS_DATA && ofs[1:0] == 2'b00) begin
			// The data window runs to the top of the 6-bit offset space, so no upper bound is needed.
			v = d[3'((ofs - OFS_DATA) >> 2)];
		end
		return v;
	endfunction

	logic [7:0] rd_byte;
	logic rd_err;
	always_comb begin
		rd_byte = 8'h00;
		rd_err = 1'b0;
		if (hit_c0) begin
			rd_byte = {full_r[0], mode_r[0], 1'b0, hdr_r[0].rtr, dben_r, dben_r, hdr_r[0].hit[0]};
		end else if (hit_c1) begin
			rd_byte = {full_r[1], mode_r[1], 1'b0, hdr_r[1].rtr, hdr_r[1].hit};
		end else if (hit_ov) begin
			rd_byte = {ovfl_r[0], ovfl_r[1], 6'h00};
		end else if (paddr >= ADDR_BUF0 && paddr < ADDR_BUF0 + BUF_SPAN) begin
			rd_byte = buf_byte(paddr[5:0], hdr_r[0], data_r[0]);
		end else if (paddr >= ADDR_BUF1 && paddr < ADDR_BUF1 + BUF_SPAN) begin
			rd_byte = buf_byte(paddr[5:0], hdr_r[1], data_r[1]);
		end else begin
			rd_err = 1'b1;
		end
	end

	// No wait states: setup, then the access phase answered on its first edge.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && rd_err;
			prdata <= (psel && !penable && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

endmodule

`default_nettype wire

// File: test/crxb_node.sv
// Model of the receive path that offers filtered messages.
`timescale 1ns/1ns
`default_nettype none
module crxb_node (
	input wire logic core_clk,
	input wire logic msg_ack,
	input wire logic msg_dropped,
	output logic msg_valid,
	output crxb_pkg::crxb_msg_s msg_in
);
	import crxb_pkg::*;
	initial begin
		msg_valid = 1'b0;
		msg_in = '0;
	end
	// An offer lasts one cycle; stale contents are inverted so nothing relies on them.
	task automatic offer(input crxb_msg_s m, output logic took, output logic drop);
		@(posedge core_clk);
		msg_valid <= 1'b1;
		msg_in <= m;
		@(posedge core_clk);
		msg_valid <= 1'b0;
		msg_in <= ~m;
		@(posedge core_clk);
		took = msg_ack;
		drop = msg_dropped;
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

// File: test/crxb_properties.sv
// Port checks for the receive buffer registers.
`timescale 1ns/1ns
`default_nettype none
module crxb_properties (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic msg_valid,
	input wire logic msg_ack,
	input wire logic msg_dropped
);
	import crxb_pkg::*;
	// ****
	// Decoded read cycles.
	// ****
	logic rd;
	logic bf;
	assign rd = pready && !pwrite && !pslverr;
	assign bf = paddr[11:6] == 6'h01 || paddr[11:6] == 6'h02;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	apb_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single answer");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0))
		else $error("read data upper bits set");
	mirror_bit_a: assert property (rd && paddr == ADDR_CON0 |-> prdata[BIT_JUMP_TABLE_OFFSET_BIT] == prdata[BIT_DBEN])
		else $error("offset bit differs from enable");
	hit_code_a: assert property (rd && paddr == ADDR_CON1 |-> prdata[2:0] <= HIT_LAST && !prdata[4])
		else $error("reserved filter hit code");
	srr_ext_a: assert property (rd && bf && paddr[5:0] == OFS_SIDL |-> !(prdata[3] && prdata[4]) && !prdata[2])
		else $error("bad identifier low byte");
	dlc_zero_a: assert property (rd && bf && paddr[5:0] == OFS_DLC |-> (prdata[7:0] & 8'hB0) == 8'h00)
		else $error("length byte reserved bits set");
	answer_once_a: assert property (msg_ack || msg_dropped |-> $past(msg_valid) && !(msg_ack && msg_dropped))
		else $error("answer without offer");
	offer_answer_a: assert property (msg_valid && !msg_ack |=> msg_ack || msg_dropped)
		else $error("offer left unanswered");
	c_take: cover property (msg_ack);
	c_drop: cover property (msg_dropped);
	c_err: cover property (pslverr);
endmodule
bind crxb_top crxb_properties props (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .prdata,
	.pready, .pslverr, .msg_valid, .msg_ack, .msg_dropped);
`default_nettype wire

// File: test/crxb_top_bench.sv
// Self-checking bench for the receive buffer registers.
`timescale 1ns/1ns
`default_nettype none
module crxb_top_bench;
	import crxb_pkg::*;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready, pslverr, msg_valid, msg_ack, msg_dropped;
	crxb_msg_s msg_in;
	int fails = 0;
	int num_checks = 0;
	logic [7:0] v, m;
	logic e, t, x;
	// ****
	// Rows: identifier and {ext, rtr, 0, hit, dlc}, then {sidh, sidl, dlc, con0}.
	// ****
	logic [28:0] r_id [4] = '{29'h5A3, 29'h7FF, 29'h1ABC_DEF5, 29'h3_0000};
	logic [7:0] r_in [4] = '{8'h08, 8'h50, 8'hC4, 8'h9F};
	logic [31:0] r_out [4] = '{32'hB460_0880, 32'hFFF0_4089, 32'hD5E8_4488, 32'h000B_0F81};
	always #10 core_clk = ~core_clk;
	crxb_top uut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .msg_valid, .msg_in, .msg_ack, .msg_dropped);
	crxb_node node (.core_clk, .msg_ack, .msg_dropped, .msg_valid, .msg_in);
	task automatic end_of_test;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] xp, input logic [7:0] g);
		num_checks++;
		if (g !== xp) begin
			fails++;
			$display("ERROR %s exp %h got %h", n, xp, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			fails++;
			end_of_test();
		end
		v = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input string n, input logic [11:0] a, input logic [7:0] xp);
		apb(1'b0, a, 8'h00);
		chk(n, xp, v);
	endtask
	function automatic crxb_msg_s mk(input logic [28:0] id, input logic ex, rr, input logic [3:0] dl,
		input logic ok, input logic [2:0] h);
		mk = {id, ex, rr, dl, 64'h8877_6655_4433_2211, ok, h};
	endfunction
	task automatic snd(input crxb_msg_s mm, input logic xp);
		logic d;
		node.offer(mm, t, d);
		chk("take", {7'h0, xp}, {7'h0, t});
		chk("drop", {7'h0, !xp}, {7'h0, d});
	endtask
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		rc("con0 rst", ADDR_CON0, CTRL_RESET);
		rc("con1 rst", ADDR_CON1, CTRL_RESET);
		rc("ovfl rst", ADDR_OVFL, 8'h00);
		apb(1'b0, 12'hFFC, 8'h00);
		chk("slverr", 8'h01, {7'h0, e});
		apb(1'b1, ADDR_CON0, 8'hFF);
		rc("con0 wr", ADDR_CON0, 8'h66);
		rc("con1 apart", ADDR_CON1, 8'h00);
		apb(1'b1, ADDR_CON0, 8'h00);
		for (int i = 0; i < 4; i++) begin
			snd(mk(r_id[i], r_in[i][7], r_in[i][6], r_in[i][3:0], 1'b1, {2'b0, r_in[i][4]}), 1'b1);
			rc("sidh", ADDR_BUF0 + OFS_SIDH, r_out[i][31:24]);
			apb(1'b0, ADDR_BUF0 + OFS_SIDL, 8'h00);
			m = r_in[i][7] ? 8'hFF : 8'hFC;
			chk("sidl", r_out[i][23:16] & m, v & m);
			rc("dlc", ADDR_BUF0 + OFS_DLC, r_out[i][15:8]);
			rc("con0", ADDR_CON0, r_out[i][7:0]);
			if (r_in[i][7]) begin
				rc("eidh", ADDR_BUF0 + OFS_EIDH, r_id[i][15:8]);
				rc("eidl", ADDR_BUF0 + OFS_EIDL, r_id[i][7:0]);
			end
			for (int k = 0; k < NUM_DATA && i == 0; k++) begin
				rc("data", ADDR_BUF0 + OFS_DATA + 12'(4 * k), 8'(8'h11 * (k + 1)));
			end
			apb(1'b1, ADDR_CON0, 8'h00);
			apb(1'b0, ADDR_CON0, 8'h00);
			chk("full clr", 8'h00, {7'h0, v[7]});
		end
		for (int md = 0; md < 4; md++) begin
			for (int k = 0; k < 3; k++) begin
				// Kinds: valid standard, valid extended, erroneous standard.
				apb(1'b1, ADDR_CON1, {1'b0, 2'(md), 5'h00});
				x = md == 3 || (k < 2 && (md == 0 || md == k + 1));
				snd(mk(29'h155, k == 1, 1'b0, 4'h1, k < 2, 3'd2), x);
				if (x) rc("con1", ADDR_CON1, {1'b1, 2'(md), 5'h02});
			end
		end
		snd(mk(29'h155, 1'b0, 1'b0, 4'h1, 1'b1, 3'd6), 1'b0);
		apb(1'b1, ADDR_CON1, 8'h00);
		apb(1'b1, ADDR_CON0, 8'h04);
		rc("mirror", ADDR_CON0, 8'h07);
		snd(mk(29'h0AA, 1'b0, 1'b0, 4'h2, 1'b1, 3'd1), 1'b1);
		snd(mk(29'h0AB, 1'b0, 1'b1, 4'h2, 1'b1, 3'd0), 1'b1);
		rc("con1 roll", ADDR_CON1, 8'h88);
		rc("sidh roll", ADDR_BUF1 + OFS_SIDH, 8'h15);
		apb(1'b1, ADDR_CON1, 8'h00);
		apb(1'b1, ADDR_CON0, 8'h00);
		snd(mk(29'h0AC, 1'b0, 1'b0, 4'h1, 1'b1, 3'd0), 1'b1);
		snd(mk(29'h7F0, 1'b0, 1'b0, 4'h1, 1'b1, 3'd1), 1'b0);
		apb(1'b0, ADDR_CON1, 8'h00);
		chk("full1", 8'h00, {7'h0, v[7]});
		rc("sidh kept", ADDR_BUF0 + OFS_SIDH, 8'h15);
		rc("ovfl", ADDR_OVFL, 8'h80);
		apb(1'b1, ADDR_OVFL, 8'h00);
		rc("ovfl clr", ADDR_OVFL, 8'h00);
		end_of_test();
	end
endmodule
`default_nettype wire
